// File: rtl/ubr_cfg.svh
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef UBR_CFG_SVH
`define UBR_CFG_SVH
`define UBR_OFF_CTRL 12'h000
`define UBR_OFF_BAUD 12'h004
`define UBR_OFF_BRKTO 12'h008
`define UBR_OFF_TXDATA 12'h00c
`define UBR_OFF_RXDATA 12'h010
`define UBR_OFF_STATUS 12'h014
`define UBR_CTRL_PAR 0
`define UBR_CTRL_STOP2 2
`define UBR_CTRL_FLOW 3
`define UBR_CTRL_BRK 4
`define UBR_CTRL_BYPASS 5
`define UBR_ST_RXFULL 0
`define UBR_ST_PERR 1
`define UBR_ST_FERR 2
`define UBR_ST_OVR 3
`define UBR_ST_TXBUSY 4
`define UBR_PAR_NONE 2'h0
`define UBR_PAR_ODD 2'h1
`define UBR_PAR_EVEN 2'h2
`define UBR_BAUD_RST 16'h01d8
`define UBR_BRKTO_RST 16'h00f4
`define UBR_CLK_NS 8
`define UBR_RATE_SCALE_NS 4096000
`define UBR_OVERSAMPLE 16
`define UBR_NCO_MOD (`UBR_RATE_SCALE_NS / `UBR_CLK_NS / `UBR_OVERSAMPLE)
`define UBR_BRK_UNIT_NS 8192
`define UBR_BRK_UNIT_CYC (`UBR_BRK_UNIT_NS / `UBR_CLK_NS)
`define UBR_BRK_SHIFT 10
`endif

// File: rtl/ubr_pkg.sv
// Types shared by the serial port with break reset and bypass
`default_nettype none
package ubr_pkg;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
  } ubr_tx_e;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
  } ubr_rx_e;
  typedef logic [1:0] ubr_par_t;
  typedef struct packed {
    logic tx;
    logic tx_oe;
    logic rts_n;
    logic rts_oe;
  } ubr_pins_s;
  typedef struct packed {
    ubr_tx_e txs;
    ubr_rx_e rxs;
    logic [14:0] acc;
    logic [3:0] tx_os;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_line;
    logic tx_pend;
    logic [3:0] rx_os;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_pbad;
    logic [7:0] rx_data;
    logic rx_full;
    logic perr;
    logic ferr;
    logic ovr;
    ubr_par_t par;
    logic stop2;
    logic flow;
    logic brk;
    logic bypass;
    logic [15:0] div;
    logic [15:0] brkto;
    logic [25:0] brk_cnt;
    logic self_rst;
    logic [31:0] rdata;
    ubr_pins_s pins;
    logic [3:0] gpio_o;
  } ubr_state_s;
endpackage
`default_nettype wire

// File: rtl/ubr_uart.sv
// Serial port with flow control, break reset, break transmit and pin bypass
`timescale 1ns/1ns
`default_nettype none
`include "ubr_cfg.svh"
module ubr_uart
  import ubr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic uart_rx,
  input wire logic uart_cts_n,
  output logic uart_tx,
  output logic uart_tx_oe,
  output logic uart_rts_n,
  output logic uart_rts_n_oe,
  input wire logic [3:0] gpio_in,
  output logic [3:0] gpio_out,
  output logic [3:0] gpio_oe,
  output logic deep_sleep,
  output logic self_reset
);
  localparam logic [16:0] NCO_MOD = 17'(`UBR_NCO_MOD);

  localparam ubr_state_s ST_RST = '{
    txs: TX_IDLE, rxs: RX_IDLE, acc: '0, tx_os: '0, tx_bit: '0, tx_sh: '0,
    tx_line: 1'b1, tx_pend: 1'b0, rx_os: '0, rx_bit: '0, rx_sh: '0, rx_pbad: 1'b0,
    rx_data: '0, rx_full: 1'b0, perr: 1'b0, ferr: 1'b0, ovr: 1'b0,
    par: `UBR_PAR_NONE, stop2: 1'b0, flow: 1'b0, brk: 1'b0, bypass: 1'b0,
    div: `UBR_BAUD_RST, brkto: `UBR_BRKTO_RST, brk_cnt: '0, self_rst: 1'b0,
    rdata: '0, pins: '0, gpio_o: '0};

  ubr_state_s s;
  ubr_state_s next_s;
  logic tick;
  logic cts_ok;
  logic [16:0] sum;

  function automatic logic par_of(input logic [7:0] d, input ubr_par_t m);
    par_of = (m == `UBR_PAR_ODD) ? ~(^d) : (^d);
  endfunction

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == `UBR_OFF_CTRL) || (a == `UBR_OFF_BAUD) || (a == `UBR_OFF_BRKTO) ||
              (a == `UBR_OFF_TXDATA) || (a == `UBR_OFF_RXDATA) || (a == `UBR_OFF_STATUS);
  endfunction

  assign pready = psel & penable;
  assign pslverr = pready & ~addr_ok(paddr);
  assign prdata = s.rdata;
  assign uart_tx = s.pins.tx;
  assign uart_tx_oe = s.pins.tx_oe;
  assign uart_rts_n = s.pins.rts_n;
  assign uart_rts_n_oe = s.pins.rts_oe;
  assign gpio_out = s.gpio_o;
  assign gpio_oe = {1'b0, s.bypass, 1'b0, s.bypass};
  assign deep_sleep = s.bypass;
  assign self_reset = s.self_rst;

  always_comb begin
    next_s = s;
    next_s.self_rst = 1'b0;
    cts_ok = ~s.flow | ~uart_cts_n;
    // Fractional divider: adding the divisor modulo 32000 gives 16 ticks per bit
    sum = {2'b00, s.acc} + {1'b0, s.div};
    tick = 1'b0;
    if (!s.bypass) begin
      if (sum >= NCO_MOD) begin
        next_s.acc = 15'(sum - NCO_MOD);
        tick = 1'b1;
      end else begin
        next_s.acc = sum[14:0];
      end
    end

    // Register reads are captured in the setup phase so read data leaves a flop
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `UBR_OFF_CTRL: next_s.rdata = {26'h0, s.bypass, s.brk, s.flow, s.stop2, s.par};
        `UBR_OFF_BAUD: next_s.rdata = {16'h0, s.div};
        `UBR_OFF_BRKTO: next_s.rdata = {16'h0, s.brkto};
        `UBR_OFF_RXDATA: next_s.rdata = {24'h0, s.rx_data};
        `UBR_OFF_STATUS: next_s.rdata = {27'h0, s.tx_pend | (s.txs != TX_IDLE),
                                         s.ovr, s.ferr, s.perr, s.rx_full};
        default: next_s.rdata = 32'h0;
      endcase
    end
    if (pready && pwrite) begin
      case (paddr)
        `UBR_OFF_CTRL: begin
          next_s.par = pwdata[`UBR_CTRL_PAR +: 2];
          next_s.stop2 = pwdata[`UBR_CTRL_STOP2];
          next_s.flow = pwdata[`UBR_CTRL_FLOW];
          next_s.brk = pwdata[`UBR_CTRL_BRK];
          // Bypass cannot be withdrawn by software, only by reset
          next_s.bypass = s.bypass | pwdata[`UBR_CTRL_BYPASS];
        end
        `UBR_OFF_BAUD: next_s.div = pwdata[15:0];
        `UBR_OFF_BRKTO: next_s.brkto = pwdata[15:0];
        `UBR_OFF_TXDATA: begin
          if (!s.tx_pend) begin
            next_s.tx_sh = pwdata[7:0];
            next_s.tx_pend = 1'b1;
          end
        end
        `UBR_OFF_STATUS: begin
          next_s.perr = s.perr & ~pwdata[`UBR_ST_PERR];
          next_s.ferr = s.ferr & ~pwdata[`UBR_ST_FERR];
          next_s.ovr = s.ovr & ~pwdata[`UBR_ST_OVR];
        end
        default: ;
      endcase
    end
    if (pready && !pwrite && paddr == `UBR_OFF_RXDATA) begin
      next_s.rx_full = 1'b0;
    end

    // Transmitter; a new frame waits out a break so the break stays clean
    if (tick) begin
      if (s.txs == TX_IDLE) begin
        if (s.tx_pend && cts_ok && !s.brk) begin
          next_s.txs = TX_START;
          next_s.tx_line = 1'b0;
          next_s.tx_os = 4'h0;
        end
      end else begin
        next_s.tx_os = s.tx_os + 4'h1;
        if (s.tx_os == 4'hf) begin
          case (s.txs)
            TX_START: begin
              next_s.txs = TX_DATA;
              next_s.tx_bit = 3'h0;
              next_s.tx_line = s.tx_sh[0];
            end
            TX_DATA: begin
              if (s.tx_bit == 3'h7) begin
                if (s.par != `UBR_PAR_NONE) begin
                  next_s.txs = TX_PAR;
                  next_s.tx_line = par_of(s.tx_sh, s.par);
                end else begin
                  next_s.txs = TX_STOP;
                  next_s.tx_line = 1'b1;
                  next_s.tx_bit = 3'h0;
                end
              end else begin
                next_s.tx_bit = s.tx_bit + 3'h1;
                next_s.tx_line = s.tx_sh[s.tx_bit + 3'h1];
              end
            end
            TX_PAR: begin
              next_s.txs = TX_STOP;
              next_s.tx_line = 1'b1;
              next_s.tx_bit = 3'h0;
            end
            TX_STOP: begin
              if (s.stop2 && s.tx_bit == 3'h0) begin
                next_s.tx_bit = 3'h1;
              end else begin
                next_s.txs = TX_IDLE;
                next_s.tx_pend = 1'b0;
              end
            end
            default: next_s.txs = TX_IDLE;
          endcase
        end
      end
    end

    // Receiver, sampling mid-bit at 16x; new data and errors win over a clear
    if (tick) begin
      case (s.rxs)
        RX_IDLE: begin
          if (!uart_rx) begin
            next_s.rxs = RX_START;
            next_s.rx_os = 4'h0;
          end
        end
        RX_START: begin
          next_s.rx_os = s.rx_os + 4'h1;
          if (s.rx_os == 4'h7) begin
            next_s.rxs = uart_rx ? RX_IDLE : RX_DATA;
            next_s.rx_os = 4'h0;
            next_s.rx_bit = 3'h0;
          end
        end
        RX_DATA: begin
          next_s.rx_os = s.rx_os + 4'h1;
          if (s.rx_os == 4'hf) begin
            next_s.rx_sh[s.rx_bit] = uart_rx;
            next_s.rx_bit = s.rx_bit + 3'h1;
            if (s.rx_bit == 3'h7) begin
              next_s.rxs = (s.par != `UBR_PAR_NONE) ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          next_s.rx_os = s.rx_os + 4'h1;
          if (s.rx_os == 4'hf) begin
            next_s.rx_pbad = uart_rx ^ par_of(s.rx_sh, s.par);
            next_s.rxs = RX_STOP;
          end
        end
        RX_STOP: begin
          next_s.rx_os = s.rx_os + 4'h1;
          if (s.rx_os == 4'hf) begin
            next_s.rxs = RX_IDLE;
            next_s.rx_data = s.rx_sh;
            next_s.rx_full = 1'b1;
            next_s.ovr = next_s.ovr | s.rx_full;
            next_s.ferr = next_s.ferr | ~uart_rx;
            next_s.perr = next_s.perr | (s.rx_pbad & (s.par != `UBR_PAR_NONE));
            next_s.rx_pbad = 1'b0;
          end
        end
        default: next_s.rxs = RX_IDLE;
      endcase
    end

    // Pins are registered; in bypass they follow the general pins a cycle late
    next_s.pins.tx_oe = 1'b1;
    next_s.pins.rts_oe = 1'b1;
    next_s.gpio_o = {1'b0, uart_cts_n, 1'b0, uart_rx};
    if (s.bypass) begin
      next_s.pins.tx = gpio_in[1];
      next_s.pins.rts_n = gpio_in[3];
    end else begin
      next_s.pins.tx = s.brk ? 1'b0 : s.tx_line;
      next_s.pins.rts_n = s.flow & s.rx_full;
    end

    // Break timer in units of 1024 clocks; asleep in bypass, so no reset there
    if (uart_rx || s.bypass) begin
      next_s.brk_cnt = 26'h0;
    end else begin
      next_s.brk_cnt = s.brk_cnt + 26'h1;
      if (s.brk_cnt[25:`UBR_BRK_SHIFT] > s.brkto) begin
        next_s = ST_RST;
        next_s.pins = s.pins;
        next_s.self_rst = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= ST_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_low_past_timeout;
    ce && !uart_rx && !s.bypass && s.brk_cnt[25:`UBR_BRK_SHIFT] > s.brkto;
  endsequence

  AST_BREAK_RESET: assert property (s_low_past_timeout |=>
                                    self_reset && s.div == `UBR_BAUD_RST)
    else $error("break timeout did not reset the block");
  AST_BREAK_RESTART: assert property (ce && uart_rx |=> s.brk_cnt == 26'h0)
    else $error("break timer did not restart on high line");
  AST_FLOW_HOLD: assert property (ce && s.flow && uart_cts_n && s.txs == TX_IDLE
                                  |=> s.txs == TX_IDLE)
    else $error("frame started while clear-to-send deasserted");
  AST_RTS_FULL: assert property (ce && !s.bypass && s.flow && s.rx_full |=> uart_rts_n)
    else $error("request-to-send not dropped with receiver full");
  AST_BREAK_TX: assert property (ce && !s.bypass && s.brk |=> !uart_tx)
    else $error("break not driven on transmit line");
  AST_BYPASS_STICKY: assert property (s.bypass |=> s.bypass && deep_sleep)
    else $error("bypass left without reset");
  AST_BYPASS_ROUTE: assert property (ce && s.bypass |=> uart_tx == $past(gpio_in[1])
                                     && gpio_out[0] == $past(uart_rx))
    else $error("bypass routing wrong");
  // Reset sampled high first, so the release edge itself is not judged
  AST_OE_AFTER_RESET: assert property (presetn && ce |=> uart_tx_oe && uart_rts_n_oe)
    else $error("port not driven after reset");
  AST_BAUD_TICK: assert property (!s.bypass && s.div == 16'h0 |-> !tick)
    else $error("tick with zero divisor");
endmodule
`default_nettype wire

// File: testbench/ubr_host_model.sv
// Serial host model: sends and receives frames on the port's lines
`timescale 1ns/1ns
`default_nettype none
module ubr_host_model #(
  parameter int BIT = 64
) (
  input wire logic pclk,
  input wire logic line_in,
  output logic line_out,
  output logic cts_n
);
  initial begin
    line_out = 1'b1;
    cts_n = 1'b0;
  end
  // Idle levels between frames, set by the bench through here
  task automatic drive(input logic l, input logic c);
    line_out <= l;
    cts_n <= c;
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Wrong parity only when the caller asks for it
  task automatic send(input logic [7:0] d, input logic [1:0] p, input logic s2,
                      input logic bad);
    @(posedge pclk);
    line_out <= 1'b0;
    gap(BIT);
    for (int i = 0; i < 8; i++) begin
      line_out <= d[i];
      gap(BIT);
    end
    if (p != 2'h0) begin
      line_out <= ((p == 2'h1) ? ~^d : ^d) ^ bad;
      gap(BIT);
    end
    line_out <= 1'b1;
    gap(s2 ? 2 * BIT : BIT);
  endtask
  task automatic recv(input logic [1:0] p, output logic [7:0] d, output logic pb,
                      output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    d = '0;
    pb = 1'b0;
    while (line_in !== 1'b0 && n < 40 * BIT) begin
      @(posedge pclk);
      n++;
    end
    if (n < 40 * BIT) begin
      gap(BIT / 2);
      ok = (line_in === 1'b0);
      for (int i = 0; i < 8; i++) begin
        gap(BIT);
        d[i] = line_in;
      end
      if (p != 2'h0) begin
        gap(BIT);
        pb = line_in;
      end
      gap(BIT);
      ok = ok & (line_in === 1'b1);
    end
  endtask
endmodule
`default_nettype wire

// File: testbench/ubr_uart_tb_top.sv
// Testbench of the serial port: register access, framing, flow, break, bypass
`timescale 1ns/1ns
`default_nettype none
`include "ubr_cfg.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module ubr_uart_tb_top;
  localparam int BIT = 64;
  // 64 clocks a bit, keeps frames short
  localparam logic [31:0] DIV = 32'h1f40;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] gpio_in = '0;
  logic ce = 1'b1;
  logic [31:0] prdata, q;
  logic pready, pslverr, uart_tx, uart_tx_oe, uart_rts_n, uart_rts_n_oe;
  logic deep_sleep, self_reset, rx_line, cts_n, e, pb, ok, s2, bad, ep;
  logic [3:0] gpio_out, gpio_oe;
  logic [7:0] d, r8;
  logic [1:0] p;
  wire logic tx_wire;
  int mismatches = 0;
  int samples_checked = 0;
  int rst_seen = 0;
  int n;
  always #4 pclk = ~pclk;
  // Pull-up holds the line when the port floats; nobody else drives it
  assign tx_wire = uart_tx_oe ? uart_tx : 1'b1;
  always @(posedge pclk) if (self_reset === 1'b1) rst_seen++;
  ubr_uart dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .uart_rx(rx_line),
    .uart_cts_n(cts_n), .uart_tx(uart_tx), .uart_tx_oe(uart_tx_oe),
    .uart_rts_n(uart_rts_n), .uart_rts_n_oe(uart_rts_n_oe), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .deep_sleep(deep_sleep),
    .self_reset(self_reset));
  ubr_host_model #(.BIT(BIT)) host_u (.pclk(pclk), .line_in(tx_wire),
    .line_out(rx_line), .cts_n(cts_n));
  task automatic end_sim();
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dw);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dw;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      mismatches++;
      end_sim();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, '0);
    `CHK(q, x)
  endtask
  task automatic settle(input int k);
    repeat (k) @(negedge pclk);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    settle(1);
    `CHK(({uart_tx_oe, uart_rts_n_oe, gpio_oe}), 6'h00)
    @(posedge pclk);
    presetn <= 1'b1;
    settle(2);
    `CHK(({uart_tx_oe, uart_rts_n_oe, uart_tx, uart_rts_n, deep_sleep}), 5'b11100)
    rd(`UBR_OFF_CTRL, 32'h0);
    rd(`UBR_OFF_BAUD, 32'h01d8);
    rd(`UBR_OFF_BRKTO, 32'h00f4);
    // Clock enable low must swallow a write
    ce <= 1'b0;
    apb(1'b1, `UBR_OFF_BRKTO, 32'h7);
    ce <= 1'b1;
    rd(`UBR_OFF_BRKTO, 32'h00f4);
    apb(1'b0, 12'h0f0, '0);
    `CHK(({e, q}), 33'h100000000)
    // 921600 bit/s: a zero byte holds the line low 9 bits, about 1221 clocks
    apb(1'b1, `UBR_OFF_BAUD, 32'h0ebf);
    apb(1'b1, `UBR_OFF_TXDATA, 32'h0);
    n = 0;
    while (uart_tx !== 1'b0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (uart_tx !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    `CHK(n >= 1208 && n <= 1233, 1'b1)
    apb(1'b1, `UBR_OFF_BAUD, DIV);
    rd(`UBR_OFF_BAUD, DIV);
    for (int i = 0; i < 4; i++) begin
      p = (i == 3) ? 2'h1 : 2'(i);
      s2 = i[0];
      bad = (i == 3);
      d = 8'h96 ^ 8'(i * 33);
      apb(1'b1, `UBR_OFF_CTRL, {29'h0, s2, p});
      host_u.send(d, p, s2, bad);
      rd(`UBR_OFF_STATUS, {30'h0, bad, 1'b1});
      rd(`UBR_OFF_RXDATA, {24'h0, d});
      apb(1'b1, `UBR_OFF_STATUS, 32'h0e);
      apb(1'b1, `UBR_OFF_TXDATA, {24'h0, ~d});
      host_u.recv(p, r8, pb, ok);
      // Inverting all eight bits keeps the byte's parity
      ep = (p == 2'h1) ? ~^d : (p == 2'h2) ? ^d : 1'b0;
      `CHK(({ok, r8, pb}), ({1'b1, ~d, ep}))
    end
    apb(1'b1, `UBR_OFF_CTRL, 32'h08);
    host_u.send(8'hc3, 2'h0, 1'b0, 1'b0);
    settle(1);
    `CHK(uart_rts_n, 1'b1)
    rd(`UBR_OFF_RXDATA, 32'hc3);
    settle(2);
    `CHK(uart_rts_n, 1'b0)
    @(posedge pclk);
    host_u.drive(1'b1, 1'b1);
    apb(1'b1, `UBR_OFF_TXDATA, 32'h69);
    settle(3 * BIT);
    `CHK(uart_tx, 1'b1)
    @(posedge pclk);
    host_u.drive(1'b1, 1'b0);
    host_u.recv(2'h0, r8, pb, ok);
    `CHK(({ok, r8}), 9'h169)
    apb(1'b1, `UBR_OFF_CTRL, 32'h10);
    settle(2);
    `CHK(uart_tx, 1'b0)
    apb(1'b1, `UBR_OFF_CTRL, 32'h0);
    settle(2);
    `CHK(uart_tx, 1'b1)
    // Timeout of one unit: fires past 2048 low clocks
    apb(1'b1, `UBR_OFF_BRKTO, 32'h1);
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      host_u.drive(1'b0, 1'b0);
      repeat (1500) @(posedge pclk);
      host_u.drive(1'b1, 1'b0);
      repeat (4) @(posedge pclk);
    end
    `CHK(rst_seen, 0)
    // Long lows read as frames with a low stop bit, the second overrunning
    rd(`UBR_OFF_STATUS, 32'h0d);
    host_u.drive(1'b0, 1'b0);
    n = 0;
    while (self_reset !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    host_u.drive(1'b1, 1'b0);
    `CHK(n >= 2040 && n < 2200, 1'b1)
    rd(`UBR_OFF_BAUD, 32'h01d8);
    apb(1'b1, `UBR_OFF_CTRL, 32'h20);
    settle(2);
    `CHK(({deep_sleep, gpio_oe}), 5'b10101)
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      gpio_in <= k[0] ? 4'b1010 : 4'b0000;
      host_u.drive(k[0], k[0]);
      settle(3);
      `CHK(({uart_rts_n, uart_tx, gpio_out[2], gpio_out[0]}), ({4{k[0]}}))
    end
    @(posedge pclk);
    presetn <= 1'b0;
    settle(2);
    `CHK(({uart_tx_oe, uart_rts_n_oe, gpio_oe}), 6'h00)
    @(posedge pclk);
    presetn <= 1'b1;
    settle(2);
    `CHK(({deep_sleep, uart_tx_oe}), 2'b01)
    end_sim();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
